// ---- dv/router_properties.sv ----
// Port checker for the input function router
`timescale 1ns/1ps
`default_nettype none
module router_properties (
  // Clock, reset and bus handshake
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Terminals and routed functions
  input wire logic [7:0] input_terminal_in,
  input wire logic excite_on_out,
  input wire logic setter_unlock_out,
  input wire logic alarm_reset_pulse_out,
  input wire logic position_preset_pulse_out,
  input wire logic position_error_clear_pulse_out,
  input wire logic [15:0] general_bit_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic req = avs_read_in | avs_write_in;
  AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest_out) else $error("no wait state");
  AST_WAIT_ONE: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait too long");
  AST_IDLE: assert property (!req |-> !avs_waitrequest_out) else $error("wait while idle");
  AST_ALARM_ONE: assert property (alarm_reset_pulse_out |=> !alarm_reset_pulse_out) else $error("alarm pulse");
  AST_PRESET_ONE: assert property (position_preset_pulse_out |=> !position_preset_pulse_out) else $error("preset");
  AST_CLEAR_ONE: assert property (position_error_clear_pulse_out |=> !position_error_clear_pulse_out) else $error("clr");
  AST_QUIET: assert property ((!avs_write_in && $stable(input_terminal_in))[*6] |=> $stable({excite_on_out,
    setter_unlock_out, alarm_reset_pulse_out, position_preset_pulse_out, general_bit_out})) else $error("spurious change");
  AST_DEFAULT_ON: assert property ($rose(arst_n_in) |-> ##[2:6] (excite_on_out && setter_unlock_out)) else $error("off");
  cover property (alarm_reset_pulse_out);
  cover property (position_preset_pulse_out);
  cover property (avs_read_in && !avs_waitrequest_out);
endmodule // router_properties
bind input_function_router router_properties router_properties_i (.core_clk_in, .arst_n_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .input_terminal_in, .excite_on_out, .setter_unlock_out, .alarm_reset_pulse_out,
  .position_preset_pulse_out, .position_error_clear_pulse_out, .general_bit_out);
`default_nettype wire

// ---- dv/switch_bank.sv ----
// Switch bank model driving the eight input terminals
`timescale 1ns/1ps
`default_nettype none
module switch_bank (
  input wire logic core_clk_in,
  input wire logic [7:0] level_in,
  output logic [7:0] input_terminal_out
);
  // Contacts settle one clock after the command
  always_ff @(posedge core_clk_in)
  begin
    input_terminal_out <= level_in;
  end
endmodule // switch_bank
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the input function router
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import router_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic wrq;
  logic [7:0] level = 8'h00;
  logic [7:0] term;
  wire [38:0] o;
  wire [2:0] pl;
  logic [5:0] sel [8];
  logic [7:0] pol;
  logic [63:0] nen;
  logic [63:0] nimg;
  int seed = 71570;
  int n_mismatch = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  switch_bank switch_bank_i (.core_clk_in(clk), .level_in(level), .input_terminal_out(term));
  input_function_router input_function_router_i (.core_clk_in(clk), .arst_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wrq), .input_terminal_in(term),
    .motion_command_out(o[16:10]), .direct_position_select_out(o[9:4]), .free_out(o[3]), .excite_on_out(o[2]),
    .stop_out(o[1]), .setter_unlock_out(o[0]), .alarm_reset_pulse_out(pl[2]), .position_preset_pulse_out(pl[1]),
    .position_error_clear_pulse_out(pl[0]), .general_bit_out(o[38:23]), .data_number_out(o[22:17]));
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      i++;
    end while (wrq !== 1'b0 && i < 50);
    if (i >= 50)
    begin
      n_mismatch++;
      summarize();
    end
    else
    begin
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task automatic pulses(input logic [7:0] v, input logic [5:0] e);
    logic [1:0] a;
    logic [1:0] p;
    logic [1:0] c;
    a = 2'h0;
    p = 2'h0;
    c = 2'h0;
    level <= v;
    repeat (8)
    begin
      @(negedge clk);
      a = a + 2'(pl[2]);
      p = p + 2'(pl[1]);
      c = c + 2'(pl[0]);
    end
    chk(64'({a, p, c}), 64'(e));
  endtask
  function automatic logic [38:0] fvec();
    logic [63:0] f;
    logic [63:0] used;
    f = 64'h0;
    used = 64'h0;
    for (int t = 0; t < 8; t++)
    begin
      used[sel[t]] = 1'b1;
      f[sel[t]] = f[sel[t]] | (level[t] ^ pol[t]);
    end
    f[0] = 1'b0;
    f[17] = f[17] | !used[17];
    f[27] = f[27] | !used[27];
    f = f & (~nen | nimg);
    return {f[47:32], f[53:48], f[7:1], f[13:8], f[16], f[17], f[18], f[27]};
  endfunction
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(64'(o[3:0]), 64'h5);
    for (int t = 0; t < 8; t++)
    begin
      bus(1'b0, OFS_SEL_BASE + 8'(4 * t), 32'h0);
      chk(64'(got), 64'({6'h18, 6'h12, 6'h10, 6'h32, 6'h31, 6'h30, 6'h04, 6'h03} >> (6 * t)) & 64'h3F);
    end
    bus(1'b0, OFS_POLARITY, 32'h0);
    chk(64'(got), 64'h0);
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    bus(1'b0, 8'hFC, 32'h0);
    chk(64'(got), 64'h0);
    bus(1'b1, OFS_SEL_BASE, 32'h19);
    bus(1'b1, OFS_SEL_BASE + 8'h04, 32'h1A);
    pulses(8'h83, 6'b000100);
    pulses(8'h00, 6'b010001);
    for (int i = 0; i < 40; i++)
    begin
      for (int t = 0; t < 8; t++)
      begin
        sel[t] = (i == 0) ? 6'h20 : (i == 1) ? 6'(32 + t) : 6'($unsigned($random(seed)) % 54);
        bus(1'b1, OFS_SEL_BASE + 8'(4 * t), 32'(sel[t]));
      end
      pol = 8'($random(seed));
      nen = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      nimg = {$random(seed), $random(seed)};
      bus(1'b1, OFS_POLARITY, 32'(pol));
      bus(1'b1, OFS_NET_IMAGE_LO, nimg[31:0]);
      bus(1'b1, OFS_NET_IMAGE_HI, nimg[63:32]);
      bus(1'b1, OFS_NET_ENABLE_LO, nen[31:0]);
      bus(1'b1, OFS_NET_ENABLE_HI, nen[63:32]);
      level <= 8'($random(seed));
      repeat (6) @(posedge clk);
      chk(64'(o), 64'(fvec()));
    end
    summarize();
  end
endmodule // tb_top
`default_nettype wire

// ---- logic/input_function_router.sv ----
// Input function router: terminals to internal command functions
// Functional notes
// - Each of the eight terminals has its own function code register selecting any listed function.
// - After reset terminals 0..7 select home, start, data bits 0..2, free, stop and alarm reset.
// - Codes are 0 unused, 1-7 motion, 8-13 direct position, 16-18 free/excite/stop, 24-27, 32-47, 48-53.
// - A function selected on several terminals is active when any of them is active.
// - Alarm reset and position error clear fire on the active-to-inactive transition.
// - Position preset fires on the inactive-to-active transition.
// - Excitation-on and setter-unlock stay active when no terminal selects them.
// - A function sourced from both a terminal and the network image runs only while both are active.
// - Each terminal has a polarity bit, 0 normally open, 1 normally closed, reset 0.
// - The six data number bits form a binary index of the operation data entry.
// - The network image of the input functions is written apart from the physical terminals.
`timescale 1ns/1ps
`default_nettype none
module input_function_router
  import router_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Avalon-MM slave
  input wire logic [router_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [router_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [router_pkg::BE_W-1:0] avs_byteenable_in,
  output logic [router_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Input terminals
  input wire logic [router_pkg::N_TERM-1:0] input_terminal_in,
  // Routed functions
  output logic [6:0] motion_command_out,
  output logic [5:0] direct_position_select_out,
  output logic free_out,
  output logic excite_on_out,
  output logic stop_out,
  output logic setter_unlock_out,
  output logic alarm_reset_pulse_out,
  output logic position_preset_pulse_out,
  output logic position_error_clear_pulse_out,
  output logic [15:0] general_bit_out,
  output logic [5:0] data_number_out
);
  import router_pkg::*;

  // All state of the block except the reset synchronizer flops
  typedef struct packed {
    logic [N_TERM-1:0][CODE_W-1:0] sel;
    logic [N_TERM-1:0] pol;
    logic [N_CODE-1:0] net_image;
    logic [N_CODE-1:0] net_enable;
    logic [N_TERM-1:0] sync_1;
    logic [N_TERM-1:0] sync_2;
    logic [N_CODE-1:0] func;
    logic alarm_reset_pulse;
    logic position_preset_pulse;
    logic position_error_clear_pulse;
    logic [DATA_W-1:0] rdata;
    logic ack;
  } state_s;

  localparam state_s STATE_RESET = '{
    sel: SEL_RESET,
    pol: POLARITY_RESET,
    net_image: NET_IMAGE_RESET,
    net_enable: NET_ENABLE_RESET,
    sync_1: '0,
    sync_2: '0,
    func: '0,
    alarm_reset_pulse: 1'b0,
    position_preset_pulse: 1'b0,
    position_error_clear_pulse: 1'b0,
    rdata: '0,
    ack: 1'b0
  };

  state_s q;
  state_s d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Byte-lane merge of a write
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [N_TERM-1:0] term_active;
  logic [N_CODE-1:0] term_func;
  logic [N_CODE-1:0] term_assigned;
  logic [N_CODE-1:0] func_next;
  logic bus_req;
  logic [2:0] sel_index;
  logic [31:0] sel_word;

  always_comb
  begin
    d = q;
    term_active = '0;
    term_func = '0;
    term_assigned = '0;
    func_next = '0;
    sel_index = avs_address_in[4:2];
    sel_word = '0;
    bus_req = avs_read_in | avs_write_in;

    // Terminal pins pass two flops first
    d.sync_1 = input_terminal_in;
    d.sync_2 = q.sync_1;

    term_active = q.sync_2 ^ q.pol;

    for (int t = 0; t < N_TERM; t++)
    begin
      if (q.sel[t] != FN_NONE)
      begin
        term_assigned[q.sel[t]] = 1'b1;
        if (term_active[t])
        begin
          term_func[q.sel[t]] = 1'b1;
        end
      end
    end

    // Permission functions default on when no terminal selects them
    if (!term_assigned[FN_EXCITE_ON])
    begin
      term_func[FN_EXCITE_ON] = 1'b1;
    end
    if (!term_assigned[FN_SETTER_UNLOCK])
    begin
      term_func[FN_SETTER_UNLOCK] = 1'b1;
    end

    for (int c = 1; c < N_CODE; c++)
    begin
      if (q.net_enable[c])
      begin
        func_next[c] = term_func[c] & q.net_image[c];
      end
      else
      begin
        func_next[c] = term_func[c];
      end
    end
    d.func = func_next;

    // Edge-triggered functions
    d.alarm_reset_pulse = q.func[FN_ALARM_RESET] & ~func_next[FN_ALARM_RESET];
    d.position_error_clear_pulse =
      q.func[FN_POSITION_ERROR_CLEAR] & ~func_next[FN_POSITION_ERROR_CLEAR];
    d.position_preset_pulse = ~q.func[FN_POSITION_PRESET] & func_next[FN_POSITION_PRESET];

    // Bus: one wait cycle, then answer
    d.ack = bus_req & ~q.ack;

    // Read data loaded while the wait state stands
    if (avs_read_in && !q.ack)
    begin
      d.rdata = '0;
      if (avs_address_in[7:5] == OFS_SEL_BASE[7:5])
      begin
        d.rdata = {26'h0, q.sel[sel_index]};
      end
      else
      begin
        unique case (avs_address_in)
          OFS_POLARITY:
          begin
            d.rdata = {24'h0, q.pol};
          end
          OFS_NET_IMAGE_LO:
          begin
            d.rdata = q.net_image[31:0];
          end
          OFS_NET_IMAGE_HI:
          begin
            d.rdata = q.net_image[63:32];
          end
          OFS_NET_ENABLE_LO:
          begin
            d.rdata = q.net_enable[31:0];
          end
          OFS_NET_ENABLE_HI:
          begin
            d.rdata = q.net_enable[63:32];
          end
          OFS_TERM_STATUS:
          begin
            d.rdata = {16'h0, term_active, q.sync_2};
          end
          OFS_FUNC_LO:
          begin
            d.rdata = q.func[31:0];
          end
          OFS_FUNC_HI:
          begin
            d.rdata = q.func[63:32];
          end
          default:
          begin
            d.rdata = '0;
          end
        endcase
      end
    end

    // Write lands at the edge that ends the cycle after the wait state
    if (avs_write_in && q.ack)
    begin
      if (avs_address_in[7:5] == OFS_SEL_BASE[7:5])
      begin
        sel_word = merge_be({26'h0, q.sel[sel_index]}, avs_writedata_in, avs_byteenable_in);
        d.sel[sel_index] = sel_word[CODE_W-1:0];
      end
      else
      begin
        unique case (avs_address_in)
          OFS_POLARITY:
          begin
            sel_word = merge_be({24'h0, q.pol}, avs_writedata_in, avs_byteenable_in);
            d.pol = sel_word[7:0];
          end
          OFS_NET_IMAGE_LO:
          begin
            d.net_image[31:0] = merge_be(q.net_image[31:0], avs_writedata_in, avs_byteenable_in);
          end
          OFS_NET_IMAGE_HI:
          begin
            d.net_image[63:32] = merge_be(q.net_image[63:32], avs_writedata_in, avs_byteenable_in);
          end
          OFS_NET_ENABLE_LO:
          begin
            d.net_enable[31:0] = merge_be(q.net_enable[31:0], avs_writedata_in, avs_byteenable_in);
          end
          OFS_NET_ENABLE_HI:
          begin
            d.net_enable[63:32] = merge_be(q.net_enable[63:32], avs_writedata_in, avs_byteenable_in);
          end
          default:
          begin
            d.rdata = q.rdata;
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= STATE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = bus_req & ~q.ack;

  // Routed functions to the output ports
  assign motion_command_out = q.func[FN_MOTION_LO +: 7];
  assign direct_position_select_out = q.func[FN_DIRECT_LO +: 6];
  assign free_out = q.func[FN_FREE];
  assign excite_on_out = q.func[FN_EXCITE_ON];
  assign stop_out = q.func[FN_STOP];
  assign setter_unlock_out = q.func[FN_SETTER_UNLOCK];
  assign alarm_reset_pulse_out = q.alarm_reset_pulse;
  assign position_preset_pulse_out = q.position_preset_pulse;
  assign position_error_clear_pulse_out = q.position_error_clear_pulse;
  assign general_bit_out = q.func[FN_GENERAL_LO +: 16];
  assign data_number_out = q.func[FN_DATA_NUMBER_LO +: 6];

endmodule // input_function_router
`default_nettype wire

// ---- logic/router_pkg.sv ----
// Constants for the input function router
`default_nettype none
package router_pkg;
  localparam int unsigned N_TERM = 8;
  localparam int unsigned CODE_W = 6;
  localparam int unsigned N_CODE = 64;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  // Byte offsets of the register map
  localparam logic [7:0] OFS_SEL_BASE = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h20;
  localparam logic [7:0] OFS_NET_IMAGE_LO = 8'h24;
  localparam logic [7:0] OFS_NET_IMAGE_HI = 8'h28;
  localparam logic [7:0] OFS_NET_ENABLE_LO = 8'h2C;
  localparam logic [7:0] OFS_NET_ENABLE_HI = 8'h30;
  localparam logic [7:0] OFS_TERM_STATUS = 8'h34;
  localparam logic [7:0] OFS_FUNC_LO = 8'h38;
  localparam logic [7:0] OFS_FUNC_HI = 8'h3C;
  // Function codes
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_MOTION_LO = 6'h01;
  localparam logic [5:0] FN_HOME = 6'h03;
  localparam logic [5:0] FN_START = 6'h04;
  localparam logic [5:0] FN_DIRECT_LO = 6'h08;
  localparam logic [5:0] FN_FREE = 6'h10;
  localparam logic [5:0] FN_EXCITE_ON = 6'h11;
  localparam logic [5:0] FN_STOP = 6'h12;
  localparam logic [5:0] FN_ALARM_RESET = 6'h18;
  localparam logic [5:0] FN_POSITION_PRESET = 6'h19;
  localparam logic [5:0] FN_POSITION_ERROR_CLEAR = 6'h1A;
  localparam logic [5:0] FN_SETTER_UNLOCK = 6'h1B;
  localparam logic [5:0] FN_GENERAL_LO = 6'h20;
  localparam logic [5:0] FN_DATA_NUMBER_LO = 6'h30;
  // Reset selections, terminal 0 in the low slot
  localparam logic [47:0] SEL_RESET = {6'h18, 6'h12, 6'h10, 6'h32, 6'h31, 6'h30, 6'h04, 6'h03};
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [63:0] NET_IMAGE_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] NET_ENABLE_RESET = 64'h0000_0000_0000_0000;
endpackage
`default_nettype wire
